// >>> sfs_status_cmd.sv
`include "sfs_defines.svh"
`default_nettype none

module sfs_status_cmd
   import sfs_pkg::*;
#(
   parameter int         WT_CYCLES = `SFS_WRITE_TIME_CYCLES,
   parameter logic [7:0] DEVICE_ID = `SFS_DEVICE_ID
)(
   input  wire logic           i_mclk,
   input  wire logic           i_reset_n,
   input  wire logic           i_sclk,
   input  wire logic           i_cs_n,
   input  wire logic           i_serial_in_io,
   input  wire logic           i_wp_n,
   input  wire sfs_array_req_t i_array_req,
   input  wire logic           i_array_done,
   output logic                o_serial_out,
   output logic                o_serial_out_en_n,
   output logic [7:0]          o_status,
   output logic                o_write_latch,
   output logic                o_busy,
   output logic                o_opcode_valid,
   output logic [7:0]          o_opcode,
   output logic                o_frame_end,
   output logic                o_array_grant,
   output logic                o_array_reject
);

   localparam int WT_W = $clog2(WT_CYCLES + 1);

   function automatic logic is_array_op(input logic [7:0] op);
      case (op)
         `SFS_OP_READ, `SFS_OP_FAST_READ, `SFS_OP_FAST_READ_DUO,
         `SFS_OP_PAGE_PROGRAM, `SFS_OP_SECTOR_ERASE, `SFS_OP_BLOCK32_ERASE,
         `SFS_OP_BLOCK64_ERASE, `SFS_OP_CHIP_ERASE_A, `SFS_OP_CHIP_ERASE_B,
         `SFS_OP_POWER_DOWN, `SFS_OP_MFR_DEV_ID, `SFS_OP_JEDEC_ID:
            is_array_op = 1'b1;
         default:
            is_array_op = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   sfs_pins_t pins_raw;
   sfs_pins_t pins;

   assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, serial_in: i_serial_in_io, wp_n: i_wp_n};

   sfs_sync #(
      .W        (4),
      .RESET_LV (4'h4)
   ) u_sync (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   (pins_raw),
      .o_sync    (pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State

   sfs_state_t      state_q,     state_d;
   logic            sclk_prev_q, cs_prev_q;
   logic [6:0]      shift_q,     shift_d;
   logic [4:0]      bit_cnt_q,   bit_cnt_d;
   logic [2:0]      out_idx_q,   out_idx_d;
   logic [7:0]      snap_q,      snap_d;
   logic [7:0]      nv_q,        nv_d;
   logic [7:0]      wr_data_q,   wr_data_d;
   logic            latch_q,     latch_d;
   logic            wr_busy_q,   wr_busy_d;
   logic            arr_busy_q,  arr_busy_d;
   logic [WT_W-1:0] wt_cnt_q,    wt_cnt_d;
   logic            so_q,        so_d;
   logic            en_n_q,      en_n_d;
   logic            opv_q,       opv_d;
   logic [7:0]      op_q,        op_d;
   logic            fend_q,      fend_d;
   logic            grant_q,     grant_d;
   logic            reject_q,    reject_d;

   logic            sclk_rise, sclk_fall, cs_rise;
   logic            busy;
   logic [7:0]      status_live;
   logic [7:0]      in_byte;
   logic [7:0]      out_byte;
   logic            locked;
   logic            prot_hit;
   sfs_state_t      st;

   assign sclk_rise = pins.sclk & ~sclk_prev_q;
   assign sclk_fall = ~pins.sclk & sclk_prev_q;
   assign cs_rise   = pins.cs_n & ~cs_prev_q;
   assign busy      = wr_busy_q | arr_busy_q;
   assign in_byte   = {shift_q, pins.serial_in};
   assign locked    = nv_q[`SFS_ST_LOCK] & ~pins.wp_n;

   // Stored bits plus live flags; bit 6 forced low
   always_comb
   begin
      status_live                      = nv_q & `SFS_ST_WRITE_MASK;
      status_live[`SFS_ST_BUSY]        = busy;
      status_live[`SFS_ST_WRITE_LATCH] = latch_q;
   end

   sfs_protect u_protect (
      .i_prot       (sfs_protect_t'({nv_q[`SFS_ST_FROM_LOW_END],
                                     nv_q[`SFS_ST_RANGE_HI:`SFS_ST_RANGE_LO]})),
      .i_whole_chip (i_array_req.whole_chip),
      .i_addr       (i_array_req.addr),
      .o_hit        (prot_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      state_d    = state_q;
      shift_d    = shift_q;
      bit_cnt_d  = bit_cnt_q;
      out_idx_d  = out_idx_q;
      snap_d     = snap_q;
      nv_d       = nv_q;
      wr_data_d  = wr_data_q;
      latch_d    = latch_q;
      wr_busy_d  = wr_busy_q;
      arr_busy_d = arr_busy_q;
      wt_cnt_d   = wt_cnt_q;
      so_d       = so_q;
      en_n_d     = en_n_q;
      opv_d      = 1'b0;
      op_d       = op_q;
      fend_d     = 1'b0;
      grant_d    = 1'b0;
      reject_d   = 1'b0;
      out_byte   = status_live;
      st         = (state_q == SFS_IDLE) ? SFS_OPCODE : state_q;

      // Timed status write; new bits land with busy falling
      if (wr_busy_q)
      begin
         if (wt_cnt_q == '0)
         begin
            wr_busy_d = 1'b0;
            nv_d      = (nv_q & ~`SFS_ST_WRITE_MASK)
                      | (wr_data_q & `SFS_ST_WRITE_MASK);
            latch_d   = 1'b0;
         end
         else
            wt_cnt_d = wt_cnt_q - WT_W'(1);
      end

      if (arr_busy_q && i_array_done)
      begin
         arr_busy_d = 1'b0;
         latch_d    = 1'b0;
      end

      // Program/erase admission from the array sequencer
      if (i_array_req.valid)
      begin
         if (latch_q && !busy && !prot_hit)
         begin
            grant_d    = 1'b1;
            arr_busy_d = 1'b1;
         end
         else
            reject_d = 1'b1;
      end

      if (cs_rise)
      begin
         fend_d  = 1'b1;
         en_n_d  = 1'b1;
         state_d = SFS_IDLE;
         // Only a frame ending exactly on the data byte commits
         if (state_q == SFS_WR_DONE && !busy && !locked)
         begin
            wr_busy_d = 1'b1;
            wt_cnt_d  = WT_W'(WT_CYCLES - 1);
         end
      end
      else if (!pins.cs_n)
      begin
         state_d = st;
         if (state_q == SFS_IDLE)
            bit_cnt_d = '0;
         if (sclk_rise)
         begin
            shift_d   = in_byte[6:0];
            bit_cnt_d = ((state_q == SFS_IDLE) ? 5'h00 : bit_cnt_q) + 5'h01;
            unique case (st)
               SFS_OPCODE:
               begin
                  if (state_q == SFS_IDLE)
                     bit_cnt_d = 5'h01;
                  else if (bit_cnt_q == `SFS_BYTE_LAST_BIT)
                  begin
                     bit_cnt_d = '0;
                     out_idx_d = 3'h7;
                     state_d   = SFS_IGNORE;
                     if (in_byte == `SFS_OP_STATUS_READ)
                        state_d = SFS_STATUS;
                     else if (busy)
                        state_d = SFS_IGNORE;
                     else if (in_byte == `SFS_OP_WRITE_ENABLE)
                        latch_d = 1'b1;
                     else if (in_byte == `SFS_OP_WRITE_DISABLE)
                        latch_d = 1'b0;
                     else if (in_byte == `SFS_OP_STATUS_WRITE)
                     begin
                        if (latch_q && !locked)
                           state_d = SFS_WR_DATA;
                     end
                     else if (in_byte == `SFS_OP_RELEASE_ID)
                        state_d = SFS_ID_DUMMY;
                     else if (is_array_op(in_byte))
                     begin
                        opv_d = 1'b1;
                        op_d  = in_byte;
                     end
                  end
               end
               SFS_WR_DATA:
               begin
                  if (bit_cnt_q == `SFS_BYTE_LAST_BIT)
                  begin
                     wr_data_d = in_byte;
                     state_d   = SFS_WR_DONE;
                  end
               end
               SFS_WR_DONE:
                  state_d = SFS_IGNORE;
               SFS_ID_DUMMY:
               begin
                  if (bit_cnt_q == `SFS_ID_DUMMY_LAST)
                     state_d = SFS_ID_OUT;
               end
               SFS_STATUS, SFS_ID_OUT, SFS_IGNORE:
                  state_d = st;
            endcase
         end
         // Fresh byte at each boundary so busy updates show
         if (sclk_fall && (st == SFS_STATUS || st == SFS_ID_OUT))
         begin
            out_byte  = (st == SFS_STATUS) ? status_live : DEVICE_ID;
            en_n_d    = 1'b0;
            out_idx_d = out_idx_q - 3'h1;
            if (out_idx_q == 3'h7)
            begin
               snap_d = out_byte;
               so_d   = out_byte[7];
            end
            else
               so_d = snap_q[out_idx_q];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         state_q     <= SFS_IDLE;
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
         shift_q     <= 7'h00;
         bit_cnt_q   <= 5'h00;
         out_idx_q   <= 3'h7;
         snap_q      <= 8'h00;
         nv_q        <= `SFS_ST_RESET;
         wr_data_q   <= 8'h00;
         latch_q     <= 1'b0;
         wr_busy_q   <= 1'b0;
         arr_busy_q  <= 1'b0;
         wt_cnt_q    <= '0;
         so_q        <= 1'b0;
         en_n_q      <= 1'b1;
         opv_q       <= 1'b0;
         op_q        <= 8'h00;
         fend_q      <= 1'b0;
         grant_q     <= 1'b0;
         reject_q    <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         sclk_prev_q <= pins.sclk;
         cs_prev_q   <= pins.cs_n;
         shift_q     <= shift_d;
         bit_cnt_q   <= bit_cnt_d;
         out_idx_q   <= out_idx_d;
         snap_q      <= snap_d;
         nv_q        <= nv_d;
         wr_data_q   <= wr_data_d;
         latch_q     <= latch_d;
         wr_busy_q   <= wr_busy_d;
         arr_busy_q  <= arr_busy_d;
         wt_cnt_q    <= wt_cnt_d;
         so_q        <= so_d;
         en_n_q      <= en_n_d;
         opv_q       <= opv_d;
         op_q        <= op_d;
         fend_q      <= fend_d;
         grant_q     <= grant_d;
         reject_q    <= reject_d;
      end
   end

   // Status and flag outputs registered separately to keep them flop-driven
   logic [7:0] status_out_q;
   logic       latch_out_q;
   logic       busy_out_q;

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         status_out_q <= `SFS_ST_RESET;
         latch_out_q  <= 1'b0;
         busy_out_q   <= 1'b0;
      end
      else
      begin
         status_out_q <= status_live;
         latch_out_q  <= latch_d;
         busy_out_q   <= wr_busy_d | arr_busy_d;
      end
   end

   assign o_serial_out      = so_q;
   assign o_serial_out_en_n = en_n_q;
   assign o_status          = status_out_q;
   assign o_write_latch     = latch_out_q;
   assign o_busy            = busy_out_q;
   assign o_opcode_valid    = opv_q;
   assign o_opcode          = op_q;
   assign o_frame_end       = fend_q;
   assign o_array_grant     = grant_q;
   assign o_array_reject    = reject_q;

endmodule // sfs_status_cmd

`default_nettype wire

// >>> sfs_defines.svh
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// Opcodes handled here
`define SFS_OP_WRITE_ENABLE  8'h06
`define SFS_OP_WRITE_DISABLE 8'h04
`define SFS_OP_STATUS_READ   8'h05
`define SFS_OP_STATUS_WRITE  8'h01
`define SFS_OP_RELEASE_ID    8'hAB

// Opcodes passed on to the array sequencer
`define SFS_OP_READ          8'h03
`define SFS_OP_FAST_READ     8'h0B
`define SFS_OP_FAST_READ_DUO 8'h3B
`define SFS_OP_PAGE_PROGRAM  8'h02
`define SFS_OP_SECTOR_ERASE  8'h20
`define SFS_OP_BLOCK32_ERASE 8'h52
`define SFS_OP_BLOCK64_ERASE 8'hD8
`define SFS_OP_CHIP_ERASE_A  8'hC7
`define SFS_OP_CHIP_ERASE_B  8'h60
`define SFS_OP_POWER_DOWN    8'hB9
`define SFS_OP_MFR_DEV_ID    8'h90
`define SFS_OP_JEDEC_ID      8'h9F

// Status byte layout
`define SFS_ST_BUSY          0
`define SFS_ST_WRITE_LATCH   1
`define SFS_ST_RANGE_LO      2
`define SFS_ST_RANGE_HI      4
`define SFS_ST_FROM_LOW_END  5
`define SFS_ST_RESERVED      6
`define SFS_ST_LOCK          7
`define SFS_ST_WRITE_MASK    8'hBC
`define SFS_ST_RESET         8'h00

// Identification byte; value is arbitrary
`define SFS_DEVICE_ID        8'h5A

// Frame layout
`define SFS_BYTE_LAST_BIT    5'h07
`define SFS_ID_DUMMY_LAST    5'h17
`define SFS_BLOCK_COUNT      7'h40

// Timing
`define SFS_MCLK_MHZ         40
`define SFS_WRITE_TIME_NS    10000000
`define SFS_WRITE_TIME_CYCLES ((`SFS_WRITE_TIME_NS * `SFS_MCLK_MHZ) / 1000)

`endif

// >>> sfs_pkg.sv
`default_nettype none

package sfs_pkg;

   // Gray codes along idle -> opcode -> data -> done
   typedef enum logic [2:0] {
      SFS_IDLE     = 3'h0,
      SFS_OPCODE   = 3'h1,
      SFS_WR_DATA  = 3'h3,
      SFS_WR_DONE  = 3'h2,
      SFS_STATUS   = 3'h6,
      SFS_ID_DUMMY = 3'h7,
      SFS_ID_OUT   = 3'h5,
      SFS_IGNORE   = 3'h4
   } sfs_state_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic serial_in;
      logic wp_n;
   } sfs_pins_t;

   typedef struct packed {
      logic        valid;
      logic        whole_chip;
      logic [23:0] addr;
   } sfs_array_req_t;

   typedef struct packed {
      logic       from_low_end;
      logic [2:0] range;
   } sfs_protect_t;

endpackage

`default_nettype wire

// >>> sfs_sync.sv
`default_nettype none

module sfs_sync
   import sfs_pkg::*;
#(
   parameter int         W        = 4,
   parameter logic [3:0] RESET_LV = 4'h0
)(
   input  wire logic         i_mclk,
   input  wire logic         i_reset_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge i_mclk)
         begin
            if (!i_reset_n)
            begin
               meta_q <= RESET_LV[g];
               sync_q <= RESET_LV[g];
            end
            else
            begin
               meta_q <= i_async[g];
               sync_q <= meta_q;
            end
         end
         assign o_sync[g] = sync_q;
      end
   endgenerate

endmodule // sfs_sync

`default_nettype wire

// >>> sfs_protect.sv
`default_nettype none

module sfs_protect
   import sfs_pkg::*;
(
   input  wire sfs_protect_t i_prot,
   input  wire logic         i_whole_chip,
   input  wire logic [23:0]  i_addr,
   output logic              o_hit
);

   logic [6:0] blocks;
   logic [6:0] blk;

   // Region in 64KB blocks, doubling per range code
   always_comb
   begin
      blocks = 7'h00;
      blk    = {1'b0, i_addr[21:16]};
      if (i_prot.range == 3'h7)
         blocks = `SFS_BLOCK_COUNT;
      else if (i_prot.range != 3'h0)
         blocks = 7'(7'h01 << (i_prot.range - 3'h1));
      if (blocks == 7'h00)
         o_hit = 1'b0;
      else if (i_whole_chip)
         o_hit = 1'b1;
      else if (i_prot.from_low_end)
         o_hit = blk < blocks;
      else
         o_hit = blk >= 7'(`SFS_BLOCK_COUNT - blocks);
   end

endmodule // sfs_protect

`default_nettype wire

// >>> sfs_status_cmd_assertions.sv
`default_nettype none

module sfs_status_cmd_assertions
   import sfs_pkg::*;
#(
   parameter int WT_CYCLES = 20
)(
   input wire logic           i_mclk,
   input wire logic           i_reset_n,
   input wire logic           i_sclk,
   input wire logic           i_cs_n,
   input wire logic           i_serial_in_io,
   input wire logic           i_wp_n,
   input wire sfs_array_req_t i_array_req,
   input wire logic           i_array_done,
   input wire logic           o_serial_out,
   input wire logic           o_serial_out_en_n,
   input wire logic [7:0]     o_status,
   input wire logic           o_write_latch,
   input wire logic           o_busy,
   input wire logic           o_opcode_valid,
   input wire logic [7:0]     o_opcode,
   input wire logic           o_frame_end,
   input wire logic           o_array_grant,
   input wire logic           o_array_reject
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   ////////////////////////////////////////////////////////////
   // Busy span of a status write; array cycles are excluded
   logic        busy_q, busy_d, sw_q, sw_d;
   logic [31:0] cnt_q, cnt_d;

   always_comb
   begin
      busy_d = o_busy;
      cnt_d  = o_busy ? cnt_q + 32'h1 : 32'h0;
      sw_d   = sw_q;
      if (o_busy && !busy_q && !o_array_grant)
         sw_d = 1'b1;
      else if (!o_busy)
         sw_d = 1'b0;
      if (!i_reset_n)
      begin
         busy_d = 1'b0;
         cnt_d  = 32'h0;
         sw_d   = 1'b0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      sw_q   <= sw_d;
   end

   ////////////////////////////////////////////////////////////
   a_busy_bit_mirror: assert property (o_status[0] == $past(o_busy))
      else $error("status bit 0 does not follow busy");
   a_latch_bit_mirror: assert property (o_status[1] == $past(o_write_latch))
      else $error("status bit 1 does not follow write latch");
   a_reserved_zero: assert property (o_status[6] == 1'b0)
      else $error("reserved status bit set");
   a_reject_unarmed: assert property (i_array_req.valid && (!o_write_latch || o_busy)
      |=> o_array_reject && !o_array_grant)
      else $error("array request granted without latch");
   a_grant_starts_busy: assert property (o_array_grant |-> o_busy && !$past(o_busy))
      else $error("grant without fresh busy");
   a_done_clears_all: assert property (i_array_done && o_busy |=> !o_busy && !o_write_latch)
      else $error("array completion left busy or latch");
   a_busy_end_latch: assert property ($fell(o_busy) |-> !o_write_latch)
      else $error("latch still set after busy ended");
   a_latch_set_idle: assert property ($rose(o_write_latch) |-> !o_busy)
      else $error("write latch set while busy");
   a_out_released: assert property (i_cs_n [*8] |-> o_serial_out_en_n)
      else $error("serial out driven while deselected");
   a_frame_end_pulse: assert property (o_frame_end |=> !o_frame_end)
      else $error("frame end longer than one cycle");
   a_opcode_not_busy: assert property (o_opcode_valid |-> !o_busy)
      else $error("opcode passed on while busy");
   a_write_time_span: assert property (!o_busy && busy_q && sw_q |->
      cnt_q >= 32'(WT_CYCLES - 1) && cnt_q <= 32'(WT_CYCLES + 1))
      else $error("status write cycle length wrong");
   a_write_time_cap: assert property (sw_q |-> cnt_q <= 32'(WT_CYCLES + 1))
      else $error("status write cycle overran");

endmodule // sfs_status_cmd_assertions

bind sfs_status_cmd sfs_status_cmd_assertions #(.WT_CYCLES(WT_CYCLES)) sfs_status_cmd_assertions_i (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
   .i_serial_in_io(i_serial_in_io), .i_wp_n(i_wp_n), .i_array_req(i_array_req),
   .i_array_done(i_array_done), .o_serial_out(o_serial_out),
   .o_serial_out_en_n(o_serial_out_en_n), .o_status(o_status),
   .o_write_latch(o_write_latch), .o_busy(o_busy), .o_opcode_valid(o_opcode_valid),
   .o_opcode(o_opcode), .o_frame_end(o_frame_end), .o_array_grant(o_array_grant),
   .o_array_reject(o_array_reject));

`default_nettype wire

// >>> sfs_host_model.sv
`default_nettype none

module sfs_host_model
(
   input  wire logic i_mclk,
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   timeunit 1ns;
   timeprecision 100ps;

   // Half period in system clocks; 4 gives 100 ns
   int half = 4;

   initial
   begin
      o_sclk <= 1'b0;
      o_cs_n <= 1'b1;
      o_mosi <= 1'b0;
   end

   // Mode 0 frame; bits leave from bit 47 down, reply lands in low bits
   task automatic frame(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
      rx = '0;
      @(posedge i_mclk);
      o_cs_n <= 1'b0;
      repeat (half) @(posedge i_mclk);
      for (int i = 0; i < nbits; i++)
      begin
         o_mosi <= tx[47 - i];
         repeat (half) @(posedge i_mclk);
         o_sclk <= 1'b1;
         repeat (half) @(posedge i_mclk);
         // Sampled late in the high phase, reply changes after the fall
         rx = {rx[46:0], i_miso};
         o_sclk <= 1'b0;
      end
      repeat (half) @(posedge i_mclk);
      o_cs_n <= 1'b1;
      // Released line shows no stale bit
      o_mosi <= ~o_mosi;
      repeat (16) @(posedge i_mclk);
   endtask

endmodule // sfs_host_model

`default_nettype wire

// >>> sfs_status_cmd_bench.sv
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
      end \
   end

module sfs_status_cmd_bench
   import sfs_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // Value is arbitrary
   localparam logic [7:0] DEV_ID = 8'h3C;

   logic           mclk, reset_n, wp_n, array_done, sclk, cs_n, mosi;
   sfs_array_req_t array_req;
   logic           serial_out, serial_out_en_n, write_latch, busy;
   logic           opcode_valid, frame_end, array_grant, array_reject;
   logic [7:0]     status, opcode;
   logic [47:0]    rx;
   int             err_total = 0;
   int             samples_checked = 0;
   int             fe_seen = 0;
   int             opv_seen = 0;

   // Pulse counters; one-cycle outputs are easy to miss by polling
   always @(posedge mclk)
   begin
      if (frame_end === 1'b1)
         fe_seen <= fe_seen + 1;
      if (opcode_valid === 1'b1)
         opv_seen <= opv_seen + 1;
   end

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   sfs_status_cmd #(.WT_CYCLES(400), .DEVICE_ID(DEV_ID)) sfs_status_cmd_i (
      .i_mclk(mclk), .i_reset_n(reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_serial_in_io(mosi), .i_wp_n(wp_n), .i_array_req(array_req),
      .i_array_done(array_done), .o_serial_out(serial_out),
      .o_serial_out_en_n(serial_out_en_n), .o_status(status), .o_write_latch(write_latch),
      .o_busy(busy), .o_opcode_valid(opcode_valid), .o_opcode(opcode),
      .o_frame_end(frame_end), .o_array_grant(array_grant), .o_array_reject(array_reject));

   sfs_host_model sfs_host_model_i (
      .i_mclk(mclk), .i_miso(serial_out), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

   ////////////////////////////////////////////////////////////
   task automatic op(input logic [7:0] code, input logic [7:0] data, input int nbits);
      int fe0;
      fe0 = fe_seen;
      sfs_host_model_i.frame({code, data, 32'h0}, nbits, rx);
      `CHK("frame end", fe0 + 1, fe_seen);
   endtask

   task automatic chk_status(input logic [7:0] exp);
      op(8'h05, 8'h00, 24);
      `CHK("status stream", {exp, exp}, rx[15:0]);
      `CHK("status port", exp, status);
      `CHK("out released", 1'b1, serial_out_en_n);
   endtask

   task automatic wait_idle;
      for (int n = 0; n < 1000 && busy !== 1'b0; n++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
      `CHK("busy done", 1'b0, busy);
   endtask

   task automatic req(input logic [23:0] a, input logic g);
      @(posedge mclk);
      array_req <= '{1'b1, 1'b0, a};
      @(posedge mclk);
      array_req <= '{1'b0, 1'b0, a};
      @(negedge mclk);
      `CHK("grant", g, array_grant);
      `CHK("reject", ~g, array_reject);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial
   begin
      reset_n    <= 1'b0;
      wp_n       <= 1'b1;
      array_done <= 1'b0;
      array_req  <= '0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_status(8'h00);
      op(8'h06, 8'h00, 8);
      `CHK("latch set", 1'b1, write_latch);
      chk_status(8'h02);
      op(8'h04, 8'h00, 8);
      `CHK("latch clear", 1'b0, write_latch);
      op(8'h01, 8'hFF, 16);
      `CHK("unarmed write", 1'b0, busy);
      op(8'h06, 8'h00, 8);
      op(8'h01, 8'hFF, 16);
      `CHK("write busy", 1'b1, busy);
      chk_status(8'h03);
      op(8'h04, 8'h00, 8);
      `CHK("ignored while busy", 1'b1, write_latch);
      wait_idle();
      chk_status(8'hBC);
      // Locked and pin low: write refused
      wp_n <= 1'b0;
      op(8'h06, 8'h00, 8);
      op(8'h01, 8'h00, 16);
      `CHK("locked write", 1'b0, busy);
      chk_status(8'hBE);
      wp_n <= 1'b1;
      op(8'h01, 8'h04, 16);
      wait_idle();
      chk_status(8'h04);
      op(8'h06, 8'h00, 8);
      op(8'h01, 8'h00, 17);
      `CHK("overlong write", 1'b0, busy);
      // Abandoned read, then a slow full one
      op(8'h05, 8'h00, 12);
      sfs_host_model_i.half = 6;
      chk_status(8'h06);
      sfs_host_model_i.half = 4;
      op(8'hFF, 8'hFF, 16);
      chk_status(8'h06);
      op(8'hAB, 8'h00, 48);
      `CHK("id stream", {DEV_ID, DEV_ID}, rx[15:0]);
      op(8'h02, 8'h00, 8);
      `CHK("opcode", 8'h02, opcode);
      `CHK("opcode pulse", 1, opv_seen);
      req(24'h3F0000, 1'b0);
      req(24'h000000, 1'b1);
      `CHK("array busy", 1'b1, busy);
      @(posedge mclk);
      array_done <= 1'b1;
      @(posedge mclk);
      array_done <= 1'b0;
      @(negedge mclk);
      `CHK("array done", 2'b00, {busy, write_latch});
      req(24'h000000, 1'b0);
      end_sim();
   end

   initial
   begin
      repeat (60000) @(posedge mclk);
      err_total++;
      end_sim();
   end

endmodule // sfs_status_cmd_bench

`default_nettype wire
